//--- shared/slc_pkg.sv
package slc_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned COMMIT_MS       = 3000;
    localparam longint unsigned COMMIT_CYC  =
        longint'(CLK_HZ) / 1000 * COMMIT_MS;
    localparam int unsigned BAUD_2400       = 2400;
    localparam int unsigned BAUD_9600       = 9600;
    localparam int unsigned BAUD_19200      = 19200;
    localparam int unsigned BAUD_38400      = 38400;
    localparam logic [16:0] DIV_2400  = 17'(CLK_HZ / BAUD_2400);
    localparam logic [16:0] DIV_9600  = 17'(CLK_HZ / BAUD_9600);
    localparam logic [16:0] DIV_19200 = 17'(CLK_HZ / BAUD_19200);
    localparam logic [16:0] DIV_38400 = 17'(CLK_HZ / BAUD_38400);

    // ****************************************
    // Register map (APB byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_SWITCH   = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_CONTROL  = 8'h08;
    localparam logic [7:0] ADDR_TXDATA   = 8'h0C;
    localparam logic [7:0] ADDR_PEND     = 8'h10;
    localparam logic [7:0] ADDR_ACTIVE   = 8'h14;
    localparam logic [7:0] ADDR_ADDRESS  = 8'h18;

    // CONTROL bits
    localparam int CTL_SETUP = 0;
    localparam int CTL_CLOSE = 1;
    localparam int CTL_SAVE_DONE = 2;

    // ****************************************
    // Stored settings word layout
    // ****************************************
    localparam int SET_W = 16;
    // Bit 0 ref used, 2:1 mode, 4:3 comparator set minus one,
    // 5 hold function, 6 high-speed trigger, 8:7 format-1,
    // 9 inch units, 10 non-space separator
    localparam logic [SET_W-1:0] SET_FACTORY = 16'h0100;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        SLC_PAR_NONE,
        SLC_PAR_EVEN,
        SLC_PAR_ODD
    } slc_parity_t;

    typedef enum logic [2:0] {
        SLC_RES_NONE,
        SLC_RES_0P1,
        SLC_RES_0P5,
        SLC_RES_1,
        SLC_RES_5,
        SLC_RES_10
    } slc_res_t;

    typedef struct packed {
        logic        speed_select_low;
        logic        speed_select_high;
        logic        char_length_select;
        logic        stop_length_select;
        logic        parity_enable_select;
        logic        parity_odd_select;
        logic        line_end_select;
        logic        link_role_select;
        logic [3:0]  unit_addr;
        logic [3:0]  chan_addr;
        logic        polarity_up;
        logic [2:0]  res_select;
    } slc_switch_t;

    typedef struct packed {
        logic [16:0] baud_div;
        logic        seven_bits;
        logic        two_stops;
        slc_parity_t parity;
        logic        cr_only;
        logic        link_master;
        logic [3:0]  unit_addr;
        logic [3:0]  chan_addr;
        logic        count_up;
        slc_res_t    resolution;
    } slc_cfg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } slc_apb_req_t;

endpackage

//--- rtl/slc_nvm.sv
`timescale 1ns/1ps
module slc_nvm
    import slc_pkg::*;
#(
    parameter int W = SET_W
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    output logic      [W-1:0] rd_data
);
    // Stored word survives reset; only the first power-up after
    // programming sees the factory value.
    logic [W-1:0] cell_q = W'(SET_FACTORY);

    always_ff @(posedge core_clk) begin
        // No store write while held in reset
        if (wr_en && !rst) begin
            cell_q <= wr_data;
        end
        rd_data <= cell_q;
    end
endmodule

//--- rtl/slc_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Speed switches select 2400/9600/19200/38400 baud
// - Char length switch: off 8, on 7
// - Stop switch: off one, on two
// - Parity: none, even, or odd
// - Line end: CR LF, or CR alone
// - RTS/CTS handshake paces transfers
// - Act only on own unit address
// - Channel address zero to fifteen, unique
// - Polarity switch on counts up push-in
// - Three resolution switches select step
// - Setup changes pending until close command
// - Committed settings kept in non-volatile store
// - Save finishes within about three seconds
// - Factory: no ref, current, preset zero
// - Factory: start, low speed, format 3, mm
// - Asterisk address matches every unit/channel
module slc_top
    import slc_pkg::*;
#(
    parameter longint unsigned COMMIT_CYCLES = COMMIT_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire slc_switch_t sw,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        cts_n,
    output logic             rts_n,
    output logic             txd,
    output slc_cfg_t         cfg,
    output logic [SET_W-1:0] settings,
    output logic             saving
);

    // ****************************************
    // State
    // ****************************************
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SHIFT
    } slc_tx_st_t;

    typedef struct packed {
        logic             sampled;
        slc_cfg_t         cfg;
        logic             in_setup;
        logic [SET_W-1:0] pend;
        logic [SET_W-1:0] active;
        logic             saving;
        logic [31:0]      save_cnt;
        logic             nvm_wr;
        logic [1:0]       load_cnt;
        slc_tx_st_t       tx_st;
        logic [11:0]      tx_sh;
        logic [3:0]       tx_left;
        logic [16:0]      baud_cnt;
        logic             txd;
        logic             rts_n;
        logic             tx_busy;
        logic             pready;
        logic [31:0]      prdata;
        logic             pslverr;
    } slc_state_t;

    slc_state_t       s_q;
    slc_state_t       s_d;
    logic [SET_W-1:0] nvm_rd;
    slc_cfg_t         dec;

    slc_nvm u_nvm (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (s_q.nvm_wr),
        .wr_data  (s_q.active),
        .rd_data  (nvm_rd)
    );

    // ****************************************
    // Switch decode
    // ****************************************
    always_comb begin
        unique case ({sw.speed_select_high, sw.speed_select_low})
            2'b00:   dec.baud_div = DIV_2400;
            2'b01:   dec.baud_div = DIV_9600;
            2'b10:   dec.baud_div = DIV_19200;
            default: dec.baud_div = DIV_38400;
        endcase
        dec.seven_bits = sw.char_length_select;
        dec.two_stops  = sw.stop_length_select;
        if (!sw.parity_enable_select) begin
            dec.parity = SLC_PAR_NONE;
        end else if (sw.parity_odd_select) begin
            dec.parity = SLC_PAR_ODD;
        end else begin
            dec.parity = SLC_PAR_EVEN;
        end
        dec.cr_only     = sw.line_end_select;
        dec.link_master = sw.link_role_select;
        dec.unit_addr   = sw.unit_addr;
        dec.chan_addr   = sw.chan_addr;
        dec.count_up    = sw.polarity_up;
        case (sw.res_select)
            3'b001:  dec.resolution = SLC_RES_0P1;
            3'b010:  dec.resolution = SLC_RES_0P5;
            3'b011:  dec.resolution = SLC_RES_1;
            3'b100:  dec.resolution = SLC_RES_5;
            3'b101:  dec.resolution = SLC_RES_10;
            default: dec.resolution = SLC_RES_NONE;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    logic        wr_acc;
    logic        rd_acc;
    logic        par_bit;
    logic [11:0] frame;
    logic [3:0]  nbits;
    logic [7:0]  unit_chr;
    logic [7:0]  chan_chr;

    always_comb begin
        s_d     = s_q;
        unit_chr = (s_q.cfg.unit_addr < 4'hA) ? 8'h30 + 8'(s_q.cfg.unit_addr)
                                              : 8'h37 + 8'(s_q.cfg.unit_addr);
        chan_chr = (s_q.cfg.chan_addr < 4'hA) ? 8'h30 + 8'(s_q.cfg.chan_addr)
                                              : 8'h37 + 8'(s_q.cfg.chan_addr);
        wr_acc  = psel && penable && pwrite;
        rd_acc  = psel && penable && !pwrite;
        par_bit = 1'b0;
        frame   = 12'hFFF;
        nbits   = 4'h0;
        s_d.nvm_wr  = 1'b0;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;

        // Latch once so a bumped switch cannot upset a live link
        if (!s_q.sampled) begin
            s_d.sampled = 1'b1;
            s_d.cfg     = dec;
        end

        // Store needs two edges to present its word
        if (s_q.load_cnt != 2'h2) begin
            s_d.load_cnt = s_q.load_cnt + 2'h1;
            s_d.active   = nvm_rd;
            s_d.pend     = nvm_rd;
        end

        if (s_q.saving) begin
            if (s_q.save_cnt == 32'(COMMIT_CYCLES - 1)) begin
                s_d.saving = 1'b0;
            end else begin
                s_d.save_cnt = s_q.save_cnt + 32'h1;
            end
        end

        // One-wait-state APB; writes during setup only touch pending copy
        if (psel && penable && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0;
            case (paddr)
                ADDR_SWITCH: begin
                    if (rd_acc) begin
                        s_d.prdata = 32'(sw);
                    end
                end
                ADDR_STATUS: begin
                    if (rd_acc) begin
                        s_d.prdata = {27'h0, s_q.tx_busy, s_q.rts_n,
                                      s_q.saving, s_q.in_setup,
                                      s_q.sampled};
                    end
                end
                ADDR_CONTROL: begin
                    if (wr_acc && pwdata[CTL_SETUP] && !s_q.saving) begin
                        s_d.in_setup = 1'b1;
                        s_d.pend     = s_q.active;
                    end
                    if (wr_acc && pwdata[CTL_CLOSE] && s_q.in_setup) begin
                        s_d.in_setup = 1'b0;
                        s_d.active   = s_q.pend;
                        s_d.nvm_wr   = 1'b1;
                        s_d.saving   = 1'b1;
                        s_d.save_cnt = 32'h0;
                    end
                end
                ADDR_TXDATA: begin
                    if (wr_acc && !s_q.tx_busy) begin
                        if (s_q.cfg.seven_bits) begin
                            par_bit = ^pwdata[6:0];
                            nbits   = 4'd9;
                            frame   = {4'hF, par_bit, pwdata[6:0]};
                        end else begin
                            par_bit = ^pwdata[7:0];
                            nbits   = 4'd10;
                            frame   = {3'h7, par_bit, pwdata[7:0]};
                        end
                        if (s_q.cfg.parity == SLC_PAR_NONE) begin
                            frame[nbits-4'd2] = 1'b1;
                            nbits = nbits - 4'd1;
                        end else if (s_q.cfg.parity == SLC_PAR_ODD) begin
                            frame[nbits-4'd2] = ~par_bit;
                        end
                        if (s_q.cfg.two_stops) begin
                            nbits = nbits + 4'd1;
                        end
                        s_d.tx_sh   = frame;
                        s_d.tx_left = nbits;
                        s_d.tx_busy = 1'b1;
                        s_d.rts_n   = 1'b0;
                    end else if (wr_acc) begin
                        s_d.pslverr = 1'b1;
                    end
                end
                ADDR_PEND: begin
                    if (wr_acc && s_q.in_setup) begin
                        s_d.pend = pwdata[SET_W-1:0];
                    end
                    s_d.prdata = 32'(s_q.pend);
                end
                ADDR_ACTIVE: begin
                    s_d.prdata = 32'(s_q.active);
                end
                ADDR_ADDRESS: begin
                    // Match flags for the unit (7:0) and channel (15:8) address bytes in pwdata
                    s_d.prdata = {30'h0,
                        (pwdata[15:8] == 8'h2A) ||
                        (pwdata[15:8] == chan_chr),
                        (pwdata[7:0] == 8'h2A) ||
                        (pwdata[7:0] == unit_chr)};
                end
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
        end

        // Transmitter waits for clear-to-send before start bit
        case (s_q.tx_st)
            TX_IDLE: begin
                s_d.txd = 1'b1;
                if (s_q.tx_busy && !cts_n) begin
                    s_d.tx_st    = TX_SHIFT;
                    s_d.txd      = 1'b0;
                    s_d.baud_cnt = s_q.cfg.baud_div - 17'h1;
                end
            end
            TX_SHIFT: begin
                if (s_q.baud_cnt != 17'h0) begin
                    s_d.baud_cnt = s_q.baud_cnt - 17'h1;
                end else if (s_q.tx_left == 4'h0) begin
                    s_d.tx_st   = TX_IDLE;
                    s_d.tx_busy = 1'b0;
                    s_d.rts_n   = 1'b1;
                    s_d.txd     = 1'b1;
                end else begin
                    s_d.txd      = s_q.tx_sh[0];
                    s_d.tx_sh    = {1'b1, s_q.tx_sh[11:1]};
                    s_d.tx_left  = s_q.tx_left - 4'h1;
                    s_d.baud_cnt = s_q.cfg.baud_div - 17'h1;
                end
            end
            default: begin
                s_d.tx_st = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q         <= '0;
            s_q.active  <= SET_FACTORY;
            s_q.pend    <= SET_FACTORY;
            s_q.txd     <= 1'b1;
            s_q.rts_n   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready   = s_q.pready;
    assign prdata   = s_q.prdata;
    assign pslverr  = s_q.pslverr;
    assign rts_n    = s_q.rts_n;
    assign txd      = s_q.txd;
    assign cfg      = s_q.cfg;
    assign settings = s_q.active;
    assign saving   = s_q.saving;

    // ****************************************
    // Checks
    // ****************************************
    sequence close_wr;
        psel && penable && pwrite && paddr == ADDR_CONTROL &&
        pwdata[CTL_CLOSE] && s_q.in_setup && !s_q.pready;
    endsequence

    chk_close_commit: assert property (
        @(posedge core_clk) disable iff (rst)
        close_wr |=> (settings == $past(s_q.pend)) && saving)
        else $error("close did not commit pending settings");

    chk_pend_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.in_setup && $stable(s_q.in_setup) && s_q.load_cnt == 2'h2
        |-> $stable(settings))
        else $error("active settings moved during setup");

    chk_cfg_stable: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.sampled |=> $stable(cfg))
        else $error("decoded configuration changed in operation");

    chk_cts_gate: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.tx_st == TX_IDLE && cts_n |=> s_q.tx_st == TX_IDLE)
        else $error("transmit started without clear to send");

    chk_start_bit: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(s_q.tx_st == TX_SHIFT) |-> !txd)
        else $error("frame did not open with a start bit");

    chk_idle_mark: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.tx_st == TX_IDLE && !s_q.tx_busy |-> txd)
        else $error("line not marking while idle");

    chk_rts_busy: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.tx_busy |-> !rts_n)
        else $error("request to send not asserted while busy");

    chk_speed_map: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(s_q.sampled) ##0 $past(sw.speed_select_low) &&
        !$past(sw.speed_select_high) |-> cfg.baud_div == DIV_9600)
        else $error("speed switches decoded wrongly");

    chk_parity_map: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(s_q.sampled) ##0 !$past(sw.parity_enable_select)
        |-> cfg.parity == SLC_PAR_NONE)
        else $error("parity disabled switch decoded wrongly");

    chk_save_ends: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.saving |-> s_q.save_cnt < 32'(COMMIT_CYCLES))
        else $error("save interval overran its bound");

endmodule

//--- tb/slc_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host end of the serial link
// ****************************************
module slc_host_model
    import slc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        rts_n,
    input  wire logic        txd,
    input  wire slc_cfg_t    cfg,
    input  wire logic [15:0] stall,
    output logic             cts_n,
    output logic      [11:0] rx_bits,
    output logic      [7:0]  rx_count
);
    int wait_q;
    int n;

    // Grant comes late on purpose, so the sender must really wait
    always @(posedge core_clk) begin
        if (rst || rts_n) begin
            wait_q <= 0;
            cts_n <= 1'b1;
        end else if (wait_q >= int'(stall)) begin
            cts_n <= 1'b0;
        end else begin
            wait_q <= wait_q + 1;
        end
    end

    // Mid-bit sampling; frame length follows the decoded framing
    always begin
        @(posedge core_clk);
        if (rst) begin
            rx_bits <= '0;
            rx_count <= '0;
        end else if (txd === 1'b0) begin
            n = 1 + (cfg.seven_bits ? 7 : 8) + (cfg.two_stops ? 2 : 1);
            n = n + ((cfg.parity != SLC_PAR_NONE) ? 1 : 0);
            repeat (int'(cfg.baud_div) / 2) @(posedge core_clk);
            for (int k = 0; k < n; k++) begin
                rx_bits[k] <= txd;
                if (k < n - 1) begin
                    repeat (int'(cfg.baud_div)) @(posedge core_clk);
                end
            end
            rx_count <= rx_count + 8'h01;
        end
    end
endmodule

//--- tb/tb_slc_top.sv
`timescale 1ns/1ps
// ****************************************
// Testbench
// ****************************************
module tb_slc_top;
    import slc_pkg::*;
    logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic        cts_n, rts_n, txd, saving;
    logic [7:0]  paddr, rx_count;
    logic [31:0] pwdata, prdata;
    logic [15:0] stall, settings;
    logic [11:0] rx_bits;
    slc_switch_t sw;
    slc_cfg_t    cfg;
    int          num_errors, checked, cyc;

    slc_top #(.COMMIT_CYCLES(50)) dut (.core_clk(core_clk), .rst(rst),
        .sw(sw), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cts_n(cts_n), .rts_n(rts_n), .txd(txd),
        .cfg(cfg), .settings(settings), .saving(saving));
    slc_host_model host (.core_clk(core_clk), .rst(rst), .rts_n(rts_n),
        .txd(txd), .cfg(cfg), .stall(stall), .cts_n(cts_n),
        .rx_bits(rx_bits), .rx_count(rx_count));

    always #2 core_clk = ~core_clk;

    // Frame at the fastest rate dominates the run time
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 95000) begin
            num_errors++;
            $display("unexpected %0t: run timed out", $time);
            results();
        end
    end

    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("unexpected %0t: %s", $time, m);
        end
    endtask

    task automatic do_reset(input int n);
        rst <= 1'b1;
        repeat (n) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        chk(n == 2, "bus answer timing");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_decode();
        slc_switch_t s;
        slc_cfg_t    e;
        logic [16:0] dv[4] = '{DIV_2400, DIV_9600, DIV_19200, DIV_38400};
        slc_res_t    rt[8] = '{SLC_RES_NONE, SLC_RES_0P1, SLC_RES_0P5,
            SLC_RES_1, SLC_RES_5, SLC_RES_10, SLC_RES_NONE, SLC_RES_NONE};
        for (int i = 0; i < 8; i++) begin
            s = '0;
            {s.speed_select_high, s.speed_select_low} = 2'(i);
            s.char_length_select = i[0];
            s.stop_length_select = i[1];
            s.parity_enable_select = (i % 4 != 0);
            s.parity_odd_select = i[1];
            s.line_end_select = i[0] ^ i[1];
            s.link_role_select = i[2];
            s.unit_addr = 4'(i * 2);
            s.chan_addr = 4'(15 - i);
            s.polarity_up = i[1];
            s.res_select = 3'(i);
            sw <= s;
            do_reset(2);
            e.parity = (i % 4 == 0) ? SLC_PAR_NONE :
                (i[1] ? SLC_PAR_ODD : SLC_PAR_EVEN);
            e.baud_div = dv[i % 4];
            chk(cfg.baud_div === e.baud_div, "speed");
            chk(cfg.seven_bits === i[0], "length");
            chk(cfg.two_stops === i[1], "stops");
            chk(cfg.parity === e.parity, "parity");
            chk(cfg.cr_only === s.line_end_select, "line end");
            chk(cfg.link_master === i[2], "role");
            chk(cfg.unit_addr === s.unit_addr, "unit");
            chk(cfg.chan_addr === s.chan_addr, "channel");
            chk(cfg.count_up === i[1], "polarity");
            chk(cfg.resolution === rt[i], "resolution");
            e = cfg;
            sw <= ~s;
            repeat (4) @(posedge core_clk);
            chk(cfg === e, "config moved");
        end
        $display("test decode done");
    endtask

    task automatic t_regs();
        slc_switch_t s;
        logic [31:0] r;
        logic        er;
        logic [15:0] q[4] = '{16'h4135, 16'h4236, 16'h2A36, 16'h412A};
        logic [1:0]  x[4] = '{2'b11, 2'b00, 2'b10, 2'b11};
        s = '0;
        s.unit_addr = 4'h5;
        s.chan_addr = 4'hA;
        sw <= s;
        do_reset(2);
        apb(1'b0, ADDR_SWITCH, 32'h0000_0000, r, er);
        chk(r === 32'(s), "switch readback");
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, ADDR_ADDRESS, {16'h0000, q[k]}, r, er);
            chk(r[1:0] === x[k], "address match");
        end
        apb(1'b0, 8'h1C, 32'h0000_0000, r, er);
        chk(er === 1'b1, "unmapped read accepted");
        $display("test regs done");
    endtask

    task automatic t_commit();
        logic [31:0] r;
        logic        er;
        int          n;
        apb(1'b0, ADDR_ACTIVE, 32'h0000_0000, r, er);
        chk(r[15:0] === SET_FACTORY, "factory word");
        chk(settings === SET_FACTORY, "factory port");
        apb(1'b1, ADDR_CONTROL, 32'(1 << CTL_SETUP), r, er);
        apb(1'b1, ADDR_PEND, 32'h0000_0A5B, r, er);
        apb(1'b0, ADDR_ACTIVE, 32'h0000_0000, r, er);
        chk(r[15:0] === SET_FACTORY, "applied before close");
        apb(1'b1, ADDR_CONTROL, 32'(1 << CTL_CLOSE), r, er);
        @(posedge core_clk);
        chk(saving === 1'b1, "no save");
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, r, er);
        chk(r[4:0] === 5'b01101, "status while saving");
        n = 0;
        while (saving !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        chk(n >= 40 && n <= 55, "save length");
        chk(settings === 16'h0A5B, "not applied");
        apb(1'b1, ADDR_PEND, 32'h0000_1234, r, er);
        apb(1'b0, ADDR_PEND, 32'h0000_0000, r, er);
        chk(r[15:0] === 16'h0A5B, "pending written outside setup");
        do_reset(2);
        apb(1'b0, ADDR_ACTIVE, 32'h0000_0000, r, er);
        chk(r[15:0] === 16'h0A5B, "not kept");
        $display("test commit done");
    endtask

    task automatic t_frame();
        slc_switch_t s;
        logic [31:0] r;
        logic        er, ok;
        logic [6:0]  d;
        logic [7:0]  c0;
        int          n;
        s = '0;
        s.speed_select_low = 1'b1;
        s.speed_select_high = 1'b1;
        s.char_length_select = 1'b1;
        s.stop_length_select = 1'b1;
        s.parity_enable_select = 1'b1;
        s.parity_odd_select = 1'b1;
        sw <= s;
        stall <= 16'd20;
        do_reset(2);
        d = 7'h35;
        c0 = rx_count;
        apb(1'b1, ADDR_TXDATA, 32'h0000_0035, r, er);
        chk(rts_n === 1'b0, "no request");
        ok = 1'b1;
        repeat (12) begin
            @(posedge core_clk);
            if (txd !== 1'b1) ok = 1'b0;
        end
        chk(ok, "sent before clear");
        repeat (100) @(posedge core_clk);
        apb(1'b1, ADDR_TXDATA, 32'h0000_0055, r, er);
        chk(er === 1'b1, "write taken while busy");
        n = 0;
        while (rx_count == c0 && n < 80000) begin
            @(posedge core_clk);
            n++;
        end
        chk(rx_count != c0, "no frame");
        chk(rx_bits[10:0] === {2'b11, ~^d, d, 1'b0}, "frame");
        repeat (int'(cfg.baud_div)) @(posedge core_clk);
        chk(rts_n === 1'b1, "request held");
        $display("test frame done");
    endtask

    task automatic results();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sw = '0;
        stall = 16'd0;
        num_errors = 0;
        checked = 0;
        cyc = 0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        t_commit();
        t_decode();
        t_regs();
        t_frame();
        results();
    end
endmodule
